/* include/blc_map.svh */
// Offsets, field positions, reset values and command codes of the boot configuration loader
`ifndef BLC_MAP_SVH
`define BLC_MAP_SVH
// ==========================================
// External memory layout
`define BLC_CFG_BASE     16'h0004
`define BLC_CFG_LEN      5'd22
`define BLC_HDR_LEN      4'd8
`define BLC_SIG0         8'he3
`define BLC_SIG1         8'h8e
`define BLC_SIG2         8'h1c
`define BLC_SIG3         8'h71
`define BLC_HSIG0        8'h33
`define BLC_HSIG1        8'hcc
`define BLC_NO_CRISIS    16'hffff
// Byte index inside the configuration block, counted from its base
`define BLC_CI_PAGE      5'd6
`define BLC_CI_HPTR      5'd8
`define BLC_CI_MODULE_CONFIG_REG      5'd10
`define BLC_CI_BUS_UNIT_CONFIG      5'd12
`define BLC_CI_IO_ZONE_CONFIG     5'd14
`define BLC_CI_SZ0       5'd16
`define BLC_CI_SZ1       5'd18
`define BLC_CI_PORT_E_ALT_ENABLE     5'd20
// Byte index inside the code header
`define BLC_HI_SIZE      3'd2
`define BLC_HI_CRISIS    3'd4
`define BLC_HI_ENTRY     3'd6
// ==========================================
// Register fields
`define BLC_MC_SHARED_MEM_ENABLE     7
`define BLC_MC_TEST      6
`define BLC_MC_SHADOW_OFF     5
`define BLC_MC_ADDR15_ENABLE      4
`define BLC_MC_EXT_IO_ENABLE     3
`define BLC_MC_CLOCK_OUT_ENABLE     2
`define BLC_MC_WIDE      1
`define BLC_MC_COPY_MASK 8'h1c
`define BLC_SZ_BW        7
`define BLC_PE_A18       1
`define BLC_CFG_RST      8'h00
`define BLC_SZ_RST       8'h80
// ==========================================
// Internal RAM map
`define BLC_RAM_DISP     16'hf010
`define BLC_DISP_LEN     7'd96
`define BLC_RAM_USER_LO  16'hf070
`define BLC_RAM_USER_END 17'h0f3c0
`define BLC_ISP_INIT     16'hf3c0
`define BLC_SP_INIT      16'hf3e0
// ==========================================
// Host commands and answers
`define BLC_CMD_LOAD     8'h90
`define BLC_CMD_EXEC     8'h91
`define BLC_CMD_STAT     8'h92
`define BLC_CMD_TEST     8'haa
`define BLC_CMD_RDGATE   8'hd0
`define BLC_CMD_WRGATE   8'hd1
`define BLC_ACK          8'hfa
`define BLC_ERR          8'hff
// ==========================================
// Software register port
`define BLC_REG_STATUS   4'h0
`define BLC_REG_OUTPORT  4'h1
`define BLC_REG_MODULE_CONFIG_REG     4'h2
`define BLC_OUTPORT_RST  8'hdf
`endif

/* include/blc_pkg.sv */
// Types shared by the boot configuration loader
package blc_pkg;
  typedef enum logic [3:0] {
    BLC_ST_STRAP, BLC_ST_TEST, BLC_ST_CFG_RD, BLC_ST_CFG_CHK, BLC_ST_HDR_RD, BLC_ST_HDR_CHK,
    BLC_ST_SUM, BLC_ST_SUM_CHK, BLC_ST_CRISIS, BLC_ST_CRISIS_WAIT, BLC_ST_APP, BLC_ST_RECOVERY
  } blc_state_e;

  typedef enum logic [2:0] {
    BLC_HS_RESTORE, BLC_HS_IDLE, BLC_HS_ARG, BLC_HS_LOAD, BLC_HS_GATE
  } blc_host_e;

  typedef struct packed {
    logic [7:0] module_config_reg;
    logic [7:0] static_zone0_config;
    logic [7:0] boot_zone_config;
    logic [7:0] io_zone_config;
    logic [7:0] bus_unit_config;
    logic [7:0] port_e_alt_enable;
    logic [7:0] page;
  } blc_cfg_s;

  typedef logic [7:0] blc_byte_t;
endpackage

/* rtl/blc_loader.sv */
// Boot configuration loader: strap sampling, external block checks, recovery command loop
`timescale 1ns/10ps
`include "blc_map.svh"

module blc_loader
  import blc_pkg::*;
#(
  parameter int unsigned DISP_BYTES = 96,
  parameter logic [7:0]  DISP_FILL  = 8'h00
)(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        bus_width_strap,
  input  wire logic        test_mode_strap,
  input  wire logic        shared_bios_strap,
  input  wire logic        power_fail_flag,
  output logic [15:0]      mem_addr,
  output logic             mem_rd,
  input  wire logic [7:0]  mem_rdata,
  output blc_cfg_s         cfg_regs,
  output logic             app_region_only,
  output logic             boot_ok_pin,
  output logic             exec_go,
  output logic [15:0]      exec_addr,
  output logic             crisis_call,
  input  wire logic        crisis_ret,
  input  wire logic        crisis_zero,
  output logic             host_enable,
  input  wire logic        host_cmd_wr,
  input  wire logic        host_data_wr,
  input  wire logic [7:0]  host_wdata,
  output logic             host_out_stb,
  output logic [7:0]       host_out,
  output logic             ram_we,
  output logic [15:0]      ram_addr,
  output logic [7:0]       ram_wdata,
  output logic [15:0]      program_sp,
  output logic [15:0]      intr_sp,
  output logic             addr20_gate,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata
);

  initial begin
    if (DISP_BYTES == 0 || DISP_BYTES > 96) $error("DISP_BYTES must be 1 to 96");
  end

  function automatic logic [15:0] blc_label_to_addr(input logic [7:0] lo, input logic [7:0] hi);
    blc_label_to_addr = {hi[6:0], lo, 1'b0};
  endfunction

  // ==========================================
  // Strap synchronisers
  logic [1:0] wide_sync_q;
  logic [1:0] test_sync_q;
  logic [1:0] shared_bios_strap_sync_q;
  // No reset: the chains keep sampling during reset, so the straps are settled when it lifts
  always_ff @(posedge sys_clk) begin
    wide_sync_q <= {wide_sync_q[0], bus_width_strap};
    test_sync_q <= {test_sync_q[0], test_mode_strap};
    shared_bios_strap_sync_q <= {shared_bios_strap_sync_q[0], shared_bios_strap};
  end
  logic strap_wide;
  logic strap_test;
  logic strap_shared_bios_strap;
  assign strap_wide = wide_sync_q[1];
  assign strap_test = test_sync_q[1];
  assign strap_shared_bios_strap = shared_bios_strap_sync_q[1];

  // ==========================================
  // Main boot sequence with byte reader
  blc_state_e   state_q;
  logic [1:0]   rd_ph_q;
  logic [16:0]  idx_q;
  blc_byte_t    cfg_q [22];
  blc_byte_t    hdr_q [8];
  logic [15:0]  hdr_base_q;
  logic [7:0]   sum_q;
  logic [16:0]  sum_len;
  logic         cfg_fail_q;
  logic         code_fail_q;
  logic         oem_fail_q;
  logic         main_go_q;
  logic [15:0]  main_addr_q;
  logic         rd_capture;
  logic         strap_pause_q;

  assign rd_capture = (rd_ph_q == 2'd2);
  // Header plus size in 256-byte units
  assign sum_len = {1'b0, hdr_q[`BLC_HI_SIZE], 8'h00} + {13'h0000, `BLC_HDR_LEN};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q       <= BLC_ST_STRAP;
      rd_ph_q       <= 2'd0;
      idx_q         <= 17'h00000;
      hdr_base_q    <= 16'h0000;
      sum_q         <= 8'h00;
      cfg_fail_q    <= 1'b0;
      code_fail_q   <= 1'b0;
      oem_fail_q    <= 1'b0;
      main_go_q     <= 1'b0;
      main_addr_q   <= 16'h0000;
      mem_rd        <= 1'b0;
      mem_addr      <= 16'h0000;
      crisis_call   <= 1'b0;
      strap_pause_q <= 1'b1;
      for (int i = 0; i < 22; i++) cfg_q[i] <= 8'h00;
      for (int i = 0; i < 8; i++) hdr_q[i] <= 8'h00;
    end else begin
      mem_rd      <= 1'b0;
      main_go_q   <= 1'b0;
      crisis_call <= 1'b0;
      // Reader: issue, wait, capture; one byte per three cycles
      if (state_q == BLC_ST_CFG_RD || state_q == BLC_ST_HDR_RD || state_q == BLC_ST_SUM) begin
        rd_ph_q <= rd_capture ? 2'd0 : rd_ph_q + 2'd1;
        if (rd_ph_q == 2'd0) begin
          mem_rd   <= 1'b1;
          mem_addr <= (state_q == BLC_ST_CFG_RD) ? `BLC_CFG_BASE + idx_q[15:0] : hdr_base_q + idx_q[15:0];
        end
      end
      case (state_q)
        BLC_ST_STRAP: begin
          // Wait for the synchronisers to settle before trusting the straps
          strap_pause_q <= 1'b0;
          if (!strap_pause_q) state_q <= strap_test ? BLC_ST_TEST : BLC_ST_CFG_RD;
        end
        BLC_ST_TEST: begin
          main_go_q   <= 1'b1;
          main_addr_q <= 16'h0000;
          state_q     <= BLC_ST_APP;
        end
        BLC_ST_CFG_RD: begin
          if (rd_capture) begin
            cfg_q[idx_q[4:0]] <= mem_rdata;
            idx_q <= idx_q + 17'd1;
            if (idx_q[4:0] == `BLC_CFG_LEN - 5'd1) state_q <= BLC_ST_CFG_CHK;
          end
        end
        BLC_ST_CFG_CHK: begin
          idx_q      <= 17'h00000;
          hdr_base_q <= {cfg_q[`BLC_CI_HPTR + 5'd1], cfg_q[`BLC_CI_HPTR]};
          if (cfg_q[0] != `BLC_SIG0 || cfg_q[1] != `BLC_SIG1 ||
              cfg_q[2] != `BLC_SIG2 || cfg_q[3] != `BLC_SIG3) begin
            cfg_fail_q <= 1'b1;
            state_q    <= BLC_ST_RECOVERY;
          end else begin
            state_q <= BLC_ST_HDR_RD;
          end
        end
        BLC_ST_HDR_RD: begin
          if (rd_capture) begin
            hdr_q[idx_q[2:0]] <= mem_rdata;
            idx_q <= idx_q + 17'd1;
            if (idx_q[2:0] == 3'd7) state_q <= BLC_ST_HDR_CHK;
          end
        end
        BLC_ST_HDR_CHK: begin
          idx_q <= 17'h00000;
          sum_q <= 8'h00;
          if (hdr_q[0] != `BLC_HSIG0 || hdr_q[1] != `BLC_HSIG1 || hdr_q[`BLC_HI_SIZE] == 8'h00) begin
            code_fail_q <= 1'b1;
            state_q     <= BLC_ST_RECOVERY;
          end else begin
            state_q <= BLC_ST_SUM;
          end
        end
        BLC_ST_SUM: begin
          if (rd_capture) begin
            sum_q <= sum_q + mem_rdata;
            idx_q <= idx_q + 17'd1;
            if (idx_q == sum_len - 17'd1) state_q <= BLC_ST_SUM_CHK;
          end
        end
        BLC_ST_SUM_CHK: begin
          if (sum_q != 8'h00) begin
            code_fail_q <= 1'b1;
            state_q     <= BLC_ST_RECOVERY;
          end else begin
            state_q <= BLC_ST_CRISIS;
          end
        end
        BLC_ST_CRISIS: begin
          if ({hdr_q[`BLC_HI_CRISIS + 3'd1], hdr_q[`BLC_HI_CRISIS]} == `BLC_NO_CRISIS) begin
            main_go_q   <= 1'b1;
            main_addr_q <= blc_label_to_addr(hdr_q[`BLC_HI_ENTRY], hdr_q[`BLC_HI_ENTRY + 3'd1]);
            state_q     <= BLC_ST_APP;
          end else begin
            crisis_call <= 1'b1;
            state_q     <= BLC_ST_CRISIS_WAIT;
          end
        end
        BLC_ST_CRISIS_WAIT: begin
          // The routine is trusted to preserve our registers and return cleanly
          if (crisis_ret) begin
            if (crisis_zero) begin
              main_go_q   <= 1'b1;
              main_addr_q <= blc_label_to_addr(hdr_q[`BLC_HI_ENTRY], hdr_q[`BLC_HI_ENTRY + 3'd1]);
              state_q     <= BLC_ST_APP;
            end else begin
              oem_fail_q <= 1'b1;
              state_q    <= BLC_ST_RECOVERY;
            end
          end
        end
        default: state_q <= state_q;
      endcase
    end
  end

  assign boot_ok_pin = (state_q == BLC_ST_APP) && !strap_test;
  assign host_enable = (state_q == BLC_ST_RECOVERY);

  // ==========================================
  // Configuration registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_regs          <= '0;
      cfg_regs.static_zone0_config <= `BLC_SZ_RST;
      cfg_regs.boot_zone_config    <= `BLC_SZ_RST;
      app_region_only   <= 1'b0;
    end else begin
      if (state_q == BLC_ST_STRAP && !strap_pause_q) begin
        cfg_regs.module_config_reg[`BLC_MC_TEST]  <= strap_test;
        cfg_regs.module_config_reg[`BLC_MC_SHADOW_OFF] <= 1'b1;
        cfg_regs.module_config_reg[`BLC_MC_WIDE]  <= strap_wide;
        if (!strap_wide) cfg_regs.static_zone0_config[`BLC_SZ_BW] <= 1'b0;
        if (strap_shared_bios_strap && !strap_test) begin
          cfg_regs.port_e_alt_enable[`BLC_PE_A18]  <= 1'b1;
          cfg_regs.module_config_reg[`BLC_MC_ADDR15_ENABLE] <= 1'b1;
        end
      end
      if (state_q == BLC_ST_CFG_CHK && cfg_q[0] == `BLC_SIG0 && cfg_q[1] == `BLC_SIG1 &&
          cfg_q[2] == `BLC_SIG2 && cfg_q[3] == `BLC_SIG3) begin
        cfg_regs.module_config_reg <= (cfg_regs.module_config_reg & ~`BLC_MC_COPY_MASK) |
                                      (cfg_q[`BLC_CI_MODULE_CONFIG_REG] & `BLC_MC_COPY_MASK);
        cfg_regs.module_config_reg[`BLC_MC_SHARED_MEM_ENABLE] <= strap_shared_bios_strap;
        cfg_regs.static_zone0_config <= {cfg_regs.static_zone0_config[`BLC_SZ_BW],
                                         cfg_q[`BLC_CI_SZ0][6:0]};
        cfg_regs.boot_zone_config    <= {1'b1, cfg_q[`BLC_CI_SZ1][6:0]};
        cfg_regs.io_zone_config      <= cfg_q[`BLC_CI_IO_ZONE_CONFIG];
        cfg_regs.bus_unit_config     <= cfg_q[`BLC_CI_BUS_UNIT_CONFIG];
        cfg_regs.port_e_alt_enable   <= cfg_q[`BLC_CI_PORT_E_ALT_ENABLE];
        cfg_regs.page                <= cfg_q[`BLC_CI_PAGE];
        app_region_only              <= 1'b1;
      end
    end
  end

  // ==========================================
  // Recovery loop: restore, then host commands
  blc_host_e    hs_q;
  logic [7:0]   cmd_q;
  blc_byte_t    arg_q [4];
  logic [2:0]   arg_cnt_q;
  logic [2:0]   arg_need_q;
  logic [15:0]  ld_addr_q;
  logic [15:0]  ld_left_q;
  logic         ld_ok_q;
  logic [6:0]   rest_idx_q;
  logic [7:0]   outport_q;
  logic         host_go_q;
  logic [15:0]  host_go_addr_q;
  logic [16:0]  ld_end;
  logic [7:0]   boot_status;

  // Meaningful only beside the last length byte, before it lands in arg_q
  assign ld_end      = {1'b0, arg_q[1], arg_q[0]} + {1'b0, host_wdata, arg_q[2]};
  assign boot_status = {power_fail_flag, 4'h0, oem_fail_q, code_fail_q, cfg_fail_q};
  assign exec_addr   = main_go_q ? main_addr_q : host_go_addr_q;
  assign exec_go     = main_go_q | host_go_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hs_q           <= BLC_HS_RESTORE;
      cmd_q          <= 8'h00;
      arg_cnt_q      <= 3'd0;
      arg_need_q     <= 3'd0;
      ld_addr_q      <= 16'h0000;
      ld_left_q      <= 16'h0000;
      ld_ok_q        <= 1'b0;
      rest_idx_q     <= 7'd0;
      host_go_q      <= 1'b0;
      host_go_addr_q <= 16'h0000;
      host_out_stb   <= 1'b0;
      host_out       <= 8'h00;
      ram_we         <= 1'b0;
      ram_addr       <= 16'h0000;
      ram_wdata      <= 8'h00;
      program_sp     <= `BLC_SP_INIT;
      intr_sp        <= `BLC_ISP_INIT;
      addr20_gate    <= 1'b0;
      for (int i = 0; i < 4; i++) arg_q[i] <= 8'h00;
    end else begin
      host_go_q    <= 1'b0;
      host_out_stb <= 1'b0;
      ram_we       <= 1'b0;
      if (state_q == BLC_ST_RECOVERY) begin
        case (hs_q)
          BLC_HS_RESTORE: begin
            // Crisis code may have trashed stacks and table
            program_sp <= `BLC_SP_INIT;
            intr_sp    <= `BLC_ISP_INIT;
            ram_we     <= 1'b1;
            ram_addr   <= `BLC_RAM_DISP + {9'h000, rest_idx_q};
            ram_wdata  <= DISP_FILL;
            rest_idx_q <= rest_idx_q + 7'd1;
            if (rest_idx_q == 7'(DISP_BYTES - 1)) hs_q <= BLC_HS_IDLE;
          end
          BLC_HS_IDLE: begin
            if (host_cmd_wr) begin
              cmd_q     <= host_wdata;
              arg_cnt_q <= 3'd0;
              case (host_wdata)
                `BLC_CMD_LOAD: begin
                  arg_need_q <= 3'd4;
                  hs_q       <= BLC_HS_ARG;
                end
                `BLC_CMD_EXEC: begin
                  arg_need_q <= 3'd2;
                  hs_q       <= BLC_HS_ARG;
                end
                `BLC_CMD_STAT: begin
                  host_out_stb <= 1'b1;
                  host_out     <= boot_status;
                end
                `BLC_CMD_TEST: begin
                  host_out_stb <= 1'b1;
                  host_out     <= `BLC_ERR;
                end
                `BLC_CMD_RDGATE: begin
                  host_out_stb <= 1'b1;
                  host_out     <= {outport_q[7:2], addr20_gate, outport_q[0]};
                end
                `BLC_CMD_WRGATE: hs_q <= BLC_HS_GATE;
                default: hs_q <= BLC_HS_IDLE;
              endcase
            end
          end
          BLC_HS_ARG: begin
            if (host_data_wr) begin
              arg_q[arg_cnt_q[1:0]] <= host_wdata;
              arg_cnt_q <= arg_cnt_q + 3'd1;
              if (arg_cnt_q == arg_need_q - 3'd1) begin
                if (cmd_q == `BLC_CMD_EXEC) begin
                  host_go_q      <= 1'b1;
                  host_go_addr_q <= blc_label_to_addr(arg_q[0], host_wdata);
                  hs_q           <= BLC_HS_IDLE;
                end else begin
                  // Judged here so the first data byte never sees the previous command's verdict
                  ld_ok_q   <= ({arg_q[1], arg_q[0]} >= `BLC_RAM_USER_LO) && (ld_end <= `BLC_RAM_USER_END);
                  ld_addr_q <= {arg_q[1], arg_q[0]};
                  ld_left_q <= {host_wdata, arg_q[2]};
                  hs_q      <= BLC_HS_LOAD;
                end
              end
            end
          end
          BLC_HS_LOAD: begin
            if (ld_left_q == 16'h0000) begin
              host_out_stb <= 1'b1;
              host_out     <= ld_ok_q ? `BLC_ACK : `BLC_ERR;
              hs_q         <= BLC_HS_IDLE;
            end else if (host_data_wr) begin
              // Out-of-range bytes are drained so the host stays in step
              ram_we    <= ld_ok_q;
              ram_addr  <= ld_addr_q;
              ram_wdata <= host_wdata;
              ld_addr_q <= ld_addr_q + 16'h0001;
              ld_left_q <= ld_left_q - 16'h0001;
            end
          end
          BLC_HS_GATE: begin
            if (host_data_wr) begin
              addr20_gate <= host_wdata[1];
              hs_q        <= BLC_HS_IDLE;
            end
          end
          default: hs_q <= BLC_HS_IDLE;
        endcase
      end
    end
  end

  // ==========================================
  // Software register port
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      outport_q <= `BLC_OUTPORT_RST;
      reg_rdata <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == `BLC_REG_OUTPORT) outport_q <= reg_wdata;
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        if (reg_addr == `BLC_REG_STATUS) reg_rdata <= {boot_ok_pin, addr20_gate, 3'b000,
                                                       oem_fail_q, code_fail_q, cfg_fail_q};
        else if (reg_addr == `BLC_REG_OUTPORT) reg_rdata <= outport_q;
        else if (reg_addr == `BLC_REG_MODULE_CONFIG_REG) reg_rdata <= cfg_regs.module_config_reg;
        else reg_rdata <= 8'h00;
      end
    end
  end

endmodule

/* sim/blc_loader_chk.sv */
// Concurrent checks on the boot configuration loader ports
`timescale 1ns/10ps
module blc_loader_chk (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        power_fail_flag,
  input wire logic        boot_ok_pin,
  input wire logic        app_region_only,
  input wire logic        host_enable,
  input wire logic        host_cmd_wr,
  input wire logic        host_data_wr,
  input wire logic [7:0]  host_wdata,
  input wire logic        host_out_stb,
  input wire logic [7:0]  host_out,
  input wire logic        addr20_gate,
  input wire logic        ram_we,
  input wire logic [15:0] ram_addr,
  input wire logic [15:0] program_sp,
  input wire logic [15:0] intr_sp,
  input wire logic        exec_go,
  input wire logic [15:0] exec_addr,
  input wire logic        crisis_ret,
  input wire logic        crisis_zero
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========================================
  // Boot outcome
  AST_BOOT_EXCL: assert property (boot_ok_pin |-> !host_enable) else $error("boot ok in recovery");
  AST_APP_ONLY: assert property ($rose(boot_ok_pin) |-> app_region_only) else $error("region open");
  AST_NO_CRISIS: assert property (crisis_ret && crisis_zero |-> ##[1:3] exec_go) else $error("no entry");
  // ==========================================
  // Recovery loop
  AST_STACKS: assert property (host_enable |-> program_sp == 16'hf3e0 && intr_sp == 16'hf3c0)
    else $error("stack pointers moved");
  AST_RAM_RANGE: assert property (ram_we |-> ram_addr >= 16'hf010 && ram_addr <= 16'hf3bf)
    else $error("ram write out of range");
  AST_STATUS: assert property (host_out_stb && $past(host_cmd_wr) && $past(host_wdata) == 8'h92
    |-> host_out[7] == $past(power_fail_flag)) else $error("status lacks power fail");
  AST_SELFTEST: assert property (host_out_stb && $past(host_cmd_wr) && $past(host_wdata) == 8'haa
    |-> host_out == 8'hff) else $error("self test answer wrong");
  AST_GATE: assert property ($changed(addr20_gate) |-> $past(host_data_wr) && addr20_gate == $past(host_wdata[1]))
    else $error("gate moved without data");
  AST_EXEC: assert property (exec_go && $past(host_data_wr) && $past(host_data_wr, 2)
    |-> exec_addr == {$past(host_wdata[6:0]), $past(host_wdata, 2), 1'b0}) else $error("bad jump");
  cover property ($rose(boot_ok_pin));
  cover property ($rose(host_enable));
  cover property (exec_go && host_enable);
endmodule

bind blc_loader blc_loader_chk u_chk (.*);

/* sim/blc_loader_tb.sv */
// Self-checking bench of the boot configuration loader
`timescale 1ns/10ps
module blc_loader_tb;
  import blc_pkg::*;
  logic        sys_clk, rst, bus_width_strap, test_mode_strap, shared_bios_strap, power_fail_flag, mem_rd;
  logic        app_region_only, boot_ok_pin, exec_go, crisis_call, crisis_ret, crisis_zero, host_enable;
  logic        host_cmd_wr, host_data_wr, host_out_stb, ram_we, addr20_gate, reg_wr, reg_rd;
  logic [15:0] mem_addr, exec_addr, ram_addr, program_sp, intr_sp, ex_q, ra_q;
  logic [7:0]  mem_rdata, host_wdata, host_out, ram_wdata, reg_wdata, reg_rdata, wd_q;
  logic [3:0]  reg_addr;
  blc_cfg_s    cfg_regs;
  int          n_errors = 0, n_checks = 0, n_stb = 0, cyc = 0;
  blc_loader #(.DISP_BYTES(8)) u_dut (.*);
  blc_mem_model u_mem (.*);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (exec_go) ex_q <= exec_addr;
    if (ram_we) {ra_q, wd_q} <= {ram_addr, ram_wdata};
    if (host_out_stb) n_stb <= n_stb + 1;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  // ==========================================
  // Shared tasks
  task automatic chk(logic [63:0] seen, logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(int n = 1);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic rreg(logic [3:0] a, logic [7:0] exp, logic wr = 0);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {wr, !wr, a, exp};
    tick();
    {reg_wr, reg_rd} <= 2'b00;
    tick();
    if (!wr) chk(reg_rdata, exp);
  endtask
  // First byte goes to the command port, the rest to the data port back to back
  task automatic send(logic [7:0] q[$]);
    foreach (q[i]) begin
      {host_cmd_wr, host_data_wr, host_wdata} <= {i == 0, i != 0, q[i]};
      tick();
    end
    {host_cmd_wr, host_data_wr} <= 2'b00;
    tick(2);
  endtask
  task automatic ans(logic [7:0] q[$], logic [7:0] exp);
    int n;
    n = n_stb;
    send(q);
    for (int i = 0; i < 20 && n_stb == n; i++) tick();
    chk(host_out, exp);
  endtask
  // Image: config block at 0004h, header at 0020h, 256 zero code bytes after it
  task automatic boot(logic [7:0] s0, logic [7:0] fix, logic [15:0] cr, logic bw, logic sb);
    logic [0:21][7:0] cfg = {s0, 72'h8e1c71160007002000, 96'hff003c005a00050000000200};
    logic [0:7][7:0] hdr = {16'h33cc, 8'h01, fix, cr[7:0], cr[15:8], 16'h4000};
    for (int i = 0; i < 22; i++) u_mem.mem[i + 4] = cfg[i];
    for (int i = 0; i < 8; i++) u_mem.mem[i + 32] = hdr[i];
    {rst, bus_width_strap, shared_bios_strap} <= {1'b1, bw, sb};
    tick(2);
    rst <= 1'b0;
    for (int i = 0; i < 3000 && !boot_ok_pin && !host_enable && !exec_go; i++) tick();
    tick(2);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_boot_ok();
    boot(8'he3, 8'hc2, 16'hffff, 1, 1);
    chk({boot_ok_pin, app_region_only}, 2'b11);
    chk(cfg_regs, 56'hbe85805a3c0207);
    chk(ex_q, 16'h0080);
    rreg(4'h2, 8'hbe);
    rreg(4'h0, 8'h80);
  endtask
  task automatic t_test();
    test_mode_strap <= 1'b1;
    boot(8'he3, 8'hc2, 16'hffff, 1, 0);
    chk({boot_ok_pin, ex_q}, 17'h00000);
    rreg(4'h2, 8'h62);
    test_mode_strap <= 1'b0;
  endtask
  task automatic t_bad_sum();
    boot(8'he3, 8'hc3, 16'hffff, 0, 0);
    chk(host_enable, 1'b1);
    chk(cfg_regs, 56'h3c05805a3c0207);
    rreg(4'h0, 8'h02);
  endtask
  task automatic t_crisis();
    for (int z = 1; z >= 0; z--) begin
      u_mem.zero = z[0];
      ex_q = 16'h0000;
      boot(8'he3, 8'h7a, 16'h1234, 1, 0);
      chk({boot_ok_pin, ex_q}, {z[0], z[0] ? 16'h0080 : 16'h0000});
      if (z == 0) rreg(4'h0, 8'h04);
    end
  endtask
  task automatic t_recovery();
    power_fail_flag <= 1'b1;
    boot(8'h00, 8'hc2, 16'hffff, 1, 0);
    rreg(4'h0, 8'h01);
    tick(12);
    chk({boot_ok_pin, ra_q}, 17'h0f017);
    ans('{8'h92}, 8'h81);
    ans('{8'haa}, 8'hff);
    rreg(4'h1, 8'h5c, 1);
    rreg(4'h1, 8'h5c);
    send('{8'h55});
    ans('{8'hd0}, 8'h5c);
    send('{8'hd1, 8'h02});
    ans('{8'hd0}, 8'h5e);
    ans('{8'h90, 8'h70, 8'hf0, 8'h02, 8'h00, 8'h11, 8'h22}, 8'hfa);
    chk({ra_q, wd_q}, 24'hf07122);
    ans('{8'h90, 8'h00, 8'hf0, 8'h01, 8'h00, 8'h33}, 8'hff);
    rreg(4'h7, 8'h00);
    send('{8'h91, 8'h34, 8'h12});
    chk(ex_q, 16'h2468);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    {bus_width_strap, test_mode_strap, shared_bios_strap, power_fail_flag} = 4'h0;
    {host_cmd_wr, host_data_wr, reg_wr, reg_rd, reg_addr} = 8'h00;
    {host_wdata, reg_wdata} = 16'h0000;
    t_boot_ok();
    t_test();
    t_bad_sum();
    t_crisis();
    t_recovery();
    wrap_up();
  end
endmodule

/* sim/blc_mem_model.sv */
// External memory and crisis routine stand-in for the loader bench
`timescale 1ns/10ps
module blc_mem_model (
  input wire logic        sys_clk,
  input wire logic [15:0] mem_addr,
  input wire logic        mem_rd,
  output logic [7:0]      mem_rdata,
  input wire logic        crisis_call,
  output logic            crisis_ret,
  output logic            crisis_zero
);
  logic [7:0] mem [512] = '{default: 8'h00};
  logic       rd_q = 1'b0;
  logic       zero = 1'b1;
  int         wait_q = 0;
  initial begin
    mem_rdata = 8'h00;
    crisis_ret = 1'b0;
    crisis_zero = 1'b0;
  end
  // Byte only in the cycle after the strobe, then a changed value so stale data is never trusted
  always @(posedge sys_clk) begin
    rd_q <= mem_rd;
    if (mem_rd) begin
      mem_rdata <= mem[mem_addr[8:0]];
    end else if (rd_q) begin
      mem_rdata <= ~mem_rdata;
    end
  end
  // Verdict flag is meaningful only beside the return pulse
  always @(posedge sys_clk) begin
    crisis_ret <= 1'b0;
    crisis_zero <= ~crisis_zero;
    if (crisis_call) begin
      wait_q <= 4;
    end else if (wait_q == 1) begin
      wait_q <= 0;
      crisis_ret <= 1'b1;
      crisis_zero <= zero;
    end else if (wait_q > 1) begin
      wait_q <= wait_q - 1;
    end
  end
endmodule
